// ==== hdl/cssc_map.svh ====
// Register offsets, field positions, reset values of the serial channel.
// Assumes byte addresses on a 32-bit classic Wishbone bus.
`ifndef CSSC_MAP_SVH
`define CSSC_MAP_SVH

// Word indices (one aligned word each; byte address = index * 4)
`define CSSC_A_SOE    6'h00
`define CSSC_A_CLR    6'h01
`define CSSC_A_MSK    6'h02
`define CSSC_A_LAT    6'h03
`define CSSC_A_DIR    6'h04
`define CSSC_A_STOP   6'h05
`define CSSC_A_CFG    6'h06
`define CSSC_A_STAT   6'h07
`define CSSC_A_START  6'h08
`define CSSC_A_DATA   6'h09
`define CSSC_A_IST    6'h0a
`define CSSC_A_ICLR   6'h0b
`define CSSC_A_IEN    6'h0c

// Field positions
`define CSSC_B_OVF    0
`define CSSC_B_PEF    1
`define CSSC_B_FEF    2
`define CSSC_B_TMSK   3
`define CSSC_B_HS     4
`define CSSC_B_TXD    0
`define CSSC_B_EOC    10
`define CSSC_B_DLS    0

// Reset values
`define CSSC_R_MSK    8'h08
`define CSSC_R_LAT    8'h17
`define CSSC_R_DIR    8'hff
`define CSSC_R_CFG    16'hc007

`endif

// ==== hdl/cssc_pkg.sv ====
// Types of the clocked serial slave channel.
// Assumes cssc_map.svh for all numeric constants.
package cssc_pkg;

    // Transmit/receive enable field
    typedef enum logic [1:0] {
        CSSC_OFF = 2'b00,
        CSSC_RX  = 2'b01,
        CSSC_TX  = 2'b10,
        CSSC_TRX = 2'b11
    } cssc_mode_e;

    // Whole state of the channel controller
    typedef struct packed {
        logic        soe;
        logic [7:0]  msk;
        logic [7:0]  lat;
        logic [7:0]  dir;
        logic [15:0] cfg;
        logic        en;
        logic        fef;
        logic        pef;
        logic        ovf;
        logic [7:0]  txd;
        logic [7:0]  rxd;
        logic        rxf;
        logic [7:0]  sh;
        logic [6:0]  rsh;
        logic [3:0]  cnt;
        logic        sck_q;
        logic        ss_q;
        logic        hs_pend;
        logic [1:0]  ist;
        logic [1:0]  ien;
        logic        irq;
        logic        ack;
        logic [31:0] dat;
        logic [4:0]  po;
        logic [4:0]  poe;
    } cssc_state_s;

endpackage : cssc_pkg

// ==== hdl/cssc_sync.sv ====
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes once stages two and three agree.
`timescale 1ns/100ps
module cssc_sync #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '1
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         srst,
    // Raw and filtered levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg;

    ////////////////////////////////////////////////////////////////
    // Stage one feeds only stage two
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s1_reg <= RST;
            s2_reg <= RST;
            s3_reg <= RST;
            dout   <= RST;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    dout[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule : cssc_sync

// ==== hdl/cssc_ctrl.sv ====
// Control of one clocked serial slave channel with busy/ready handshake.
// Assumes a classic Wishbone master and an external master driving sck/select.
// Notes on behaviour
// - Engine drives data pin only if enabled
// - Clear bit 2 clears framing error
// - Clear bit 1 clears parity error
// - Clear bit 0 clears overrun error
// - Stop bit clears channel enable status
// - Mode field: off, rx, tx, both
// - Error interrupt only when control bit set
// - Select release: busy high, then input
// - Select release: data pin becomes input
// - Direction bit 0 output, 1 input
// - Transfer mask 1 blocks transfer interrupt
// - Length bit: 0 seven, 1 eight bits
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`include "cssc_map.svh"
module cssc_ctrl (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Link pins
    input  wire logic        sck_i,
    input  wire logic        si_i,
    input  wire logic        ss_n_i,
    // Port 0 pins 4..0
    output logic      [4:0]  p0_o,
    output logic      [4:0]  p0_oe,
    // Interrupt
    output logic             irq_o
);
    import cssc_pkg::*;

    cssc_state_s s, n;
    logic [2:0]  pin_f;
    logic        sck_f, si_f, ss_f;
    logic        rel, sel_go, act, rise, fall, xfer;
    logic        fe, pe, ov, wr, rd, sbit;
    logic [5:0]  adr;
    logic [3:0]  len;
    logic [7:0]  rxv;
    cssc_mode_e  mode;

    // Frame length in bits from the length bit
    function automatic logic [3:0] frame_len(input logic dls);
        frame_len = dls ? 4'd8 : 4'd7;
    endfunction : frame_len

    // Byte-lane merge of a byte-wide register
    function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] v,
                                        input logic en);
        lane = en ? v : old;
    endfunction : lane

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers; sck and select idle high
    cssc_sync #(
        .W   (3),
        .RST (3'b111)
    ) u_sync (
        .clk_sys (clk_sys),
        .srst    (srst),
        .din     ({sck_i, si_i, ss_n_i}),
        .dout    (pin_f)
    );

    assign sck_f = pin_f[2];
    assign si_f  = pin_f[1];
    assign ss_f  = pin_f[0];

    // Bus decode; a write lands at the edge where the master samples ack high
    assign adr = wb_adr_i[7:2];
    assign wr  = wb_cyc_i & wb_stb_i & s.ack & wb_we_i;
    assign rd  = wb_cyc_i & wb_stb_i & ~s.ack & ~wb_we_i;

    ////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        n      = s;
        n.ack  = wb_cyc_i & wb_stb_i & ~s.ack;
        n.dat  = 32'h0000_0000;
        mode   = cssc_mode_e'(s.cfg[15:14]);
        len    = frame_len(s.cfg[`CSSC_B_DLS]);
        rel    = ss_f & ~s.ss_q;
        sel_go = ~ss_f & s.ss_q;
        act    = s.en & ~ss_f & (mode != CSSC_OFF);
        rise   = act & sck_f & ~s.sck_q;
        fall   = act & ~sck_f & s.sck_q;
        xfer   = 1'b0;
        fe     = 1'b0;
        pe     = 1'b0;
        ov     = 1'b0;
        rxv    = s.cfg[`CSSC_B_DLS] ? {s.rsh, si_f} : {1'b0, s.rsh[5:0], si_f};
        sbit   = s.cfg[`CSSC_B_DLS] ? s.sh[7] : s.sh[6];
        n.sck_q = sck_f;
        n.ss_q  = ss_f;

        // Register writes
        if (wr) begin
            unique case (adr)
                `CSSC_A_SOE:   n.soe = wb_sel_i[0] ? wb_dat_i[0] : s.soe;
                `CSSC_A_MSK:   n.msk = lane(s.msk, wb_dat_i[7:0], wb_sel_i[0]);
                `CSSC_A_LAT:   n.lat = lane(s.lat, wb_dat_i[7:0], wb_sel_i[0]);
                `CSSC_A_DIR:   n.dir = lane(s.dir, wb_dat_i[7:0], wb_sel_i[0]);
                `CSSC_A_DATA:  n.txd = lane(s.txd, wb_dat_i[7:0], wb_sel_i[0]);
                `CSSC_A_IEN:   n.ien = wb_sel_i[0] ? wb_dat_i[1:0] : s.ien;
                `CSSC_A_CFG: begin
                    n.cfg[7:0]  = lane(s.cfg[7:0], wb_dat_i[7:0], wb_sel_i[0]);
                    n.cfg[15:8] = lane(s.cfg[15:8], wb_dat_i[15:8], wb_sel_i[1]);
                end
                `CSSC_A_CLR: begin
                    if (wb_sel_i[0] && wb_dat_i[`CSSC_B_FEF]) n.fef = 1'b0;
                    if (wb_sel_i[0] && wb_dat_i[`CSSC_B_PEF]) n.pef = 1'b0;
                    if (wb_sel_i[0] && wb_dat_i[`CSSC_B_OVF]) n.ovf = 1'b0;
                end
                `CSSC_A_STOP: begin
                    if (wb_sel_i[0] && wb_dat_i[0]) n.en = 1'b0;
                end
                `CSSC_A_START: begin
                    if (wb_sel_i[0] && wb_dat_i[0]) n.en = 1'b1;
                end
                `CSSC_A_ICLR: begin
                    if (wb_sel_i[0]) n.ist = s.ist & ~wb_dat_i[1:0];
                end
                default: ;
            endcase
        end

        // Register reads; trigger registers read as zero
        if (rd) begin
            unique case (adr)
                `CSSC_A_SOE:   n.dat[0]    = s.soe;
                `CSSC_A_MSK:   n.dat[7:0]  = s.msk;
                `CSSC_A_LAT:   n.dat[7:0]  = s.lat;
                `CSSC_A_DIR:   n.dat[7:0]  = s.dir;
                `CSSC_A_CFG:   n.dat[15:0] = s.cfg;
                `CSSC_A_STAT:  n.dat[7:0]  = {s.en, 3'b000, s.rxf, s.fef, s.pef, s.ovf};
                `CSSC_A_IST:   n.dat[1:0]  = s.ist;
                `CSSC_A_IEN:   n.dat[1:0]  = s.ien;
                `CSSC_A_DATA: begin
                    n.dat[7:0] = s.rxd;
                    n.rxf      = 1'b0;
                end
                default:       n.dat = 32'h0000_0000;
            endcase
        end

        // Shift engine: sample on rising, shift out on falling sck
        if (sel_go) begin
            n.sh  = s.txd;
            n.cnt = 4'd0;
        end
        if (rise) begin
            n.rsh = {s.rsh[5:0], si_f};
            n.cnt = s.cnt + 4'd1;
            if (s.cnt + 4'd1 == len) begin
                xfer  = 1'b1;
                n.cnt = 4'd0;
                n.sh  = s.txd;
            end
        end
        if (fall && s.cnt != 4'd0) begin
            n.sh = {s.sh[6:0], 1'b0};
        end

        // Receive side and error events
        if (xfer && mode[0]) begin
            ov    = s.rxf;
            pe    = s.cfg[9] & ((^rxv) ^ s.cfg[8]);
            n.rxd = rxv;
            n.rxf = 1'b1;
        end
        fe = rel & s.en & (mode != CSSC_OFF) & (s.cnt != 4'd0);
        // Hardware set wins over a clear in the same cycle
        if (fe) n.fef = 1'b1;
        if (pe) n.pef = 1'b1;
        if (ov) n.ovf = 1'b1;

        // Select release: busy level and data pin release first, then release the handshake pin
        n.hs_pend = rel;
        if (rel) begin
            n.lat[`CSSC_B_HS]  = 1'b1;
            n.dir[`CSSC_B_TXD] = 1'b1;
        end
        if (s.hs_pend) begin
            n.dir[`CSSC_B_HS] = 1'b1;
        end

        // Interrupt status and level output
        if (xfer) n.ist[0] = 1'b1;
        if ((fe | pe | ov) && s.cfg[`CSSC_B_EOC]) n.ist[1] = 1'b1;
        n.irq = |({s.ist[1], s.ist[0] & ~s.msk[`CSSC_B_TMSK]} & s.ien);

        // Pins: 0 drives, 1 releases; engine owns data pin only when enabled
        n.poe = ~s.dir[4:0];
        n.po  = s.lat[4:0];
        if (s.soe && mode[1] && act) begin
            n.po[`CSSC_B_TXD] = sbit;
        end
    end

    ////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s       <= '0;
            s.msk   <= `CSSC_R_MSK;
            s.lat   <= `CSSC_R_LAT;
            s.dir   <= `CSSC_R_DIR;
            s.cfg   <= `CSSC_R_CFG;
            s.sck_q <= 1'b1;
            s.ss_q  <= 1'b1;
            s.po    <= 5'h17;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o = s.dat;
    assign wb_ack_o = s.ack;
    assign p0_o     = s.po;
    assign p0_oe    = s.poe;
    assign irq_o    = s.irq;

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    property p_soe_off;
        !s.soe |=> p0_o[0] == $past(s.lat[0]);
    endproperty
    a_soe_off: assert property (p_soe_off) else $error("data pin driven while output disabled");

    property p_clr_fe;
        wr && adr == `CSSC_A_CLR && wb_sel_i[0] && wb_dat_i[2] && !fe |=> !s.fef;
    endproperty
    a_clr_fe: assert property (p_clr_fe) else $error("framing flag not cleared");

    property p_clr_pe;
        wr && adr == `CSSC_A_CLR && wb_sel_i[0] && wb_dat_i[1] && !pe |=> !s.pef;
    endproperty
    a_clr_pe: assert property (p_clr_pe) else $error("parity flag not cleared");

    property p_clr_ov;
        wr && adr == `CSSC_A_CLR && wb_sel_i[0] && !wb_dat_i[0] && s.ovf |=> s.ovf;
    endproperty
    a_clr_ov: assert property (p_clr_ov) else $error("overrun flag lost on zero write");

    property p_stop;
        wr && adr == `CSSC_A_STOP && wb_sel_i[0] && wb_dat_i[0] |=> !s.en ##1 !xfer;
    endproperty
    a_stop: assert property (p_stop) else $error("channel still enabled after stop");

    property p_mode_off;
        s.cfg[15:14] == 2'b00 |-> !xfer && !fe;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("transfer while mode off");

    property p_eoc;
        !s.cfg[10] && !s.ist[1] |=> !s.ist[1];
    endproperty
    a_eoc: assert property (p_eoc) else $error("error interrupt while suppressed");

    property p_release;
        rel |=> s.lat[4] && s.dir[0] ##1 s.dir[4] ##1 p0_o[4] && !p0_oe[4];
    endproperty
    a_release: assert property (p_release) else $error("release order wrong");

    property p_tmask;
        s.msk[3] && !(s.ist[1] && s.ien[1]) |=> !irq_o;
    endproperty
    a_tmask: assert property (p_tmask) else $error("masked transfer interrupt raised");

    property p_trig_rd;
        rd && (adr == `CSSC_A_CLR || adr == `CSSC_A_STOP) |=> wb_ack_o && wb_dat_o == 32'h0;
    endproperty
    a_trig_rd: assert property (p_trig_rd) else $error("trigger register read nonzero");

    // Pin, length, mode and interrupt level checks
    property p_hs_busy;
        s.lat[`CSSC_B_HS] |=> p0_o[4];
    endproperty
    a_hs_busy: assert property (p_hs_busy) else $error("handshake not busy with latch set");

    property p_hs_ready;
        !s.lat[`CSSC_B_HS] |=> !p0_o[4];
    endproperty
    a_hs_ready: assert property (p_hs_ready) else $error("handshake not ready with latch clear");

    property p_txd_rel;
        rel |=> s.dir[`CSSC_B_TXD] ##1 !p0_oe[0];
    endproperty
    a_txd_rel: assert property (p_txd_rel) else $error("data pin still driven after release");

    property p_dir_out;
        !s.dir[0] |=> p0_oe[0];
    endproperty
    a_dir_out: assert property (p_dir_out) else $error("output direction not driving");

    property p_dir_in;
        s.dir[4] |=> !p0_oe[4];
    endproperty
    a_dir_in: assert property (p_dir_in) else $error("input direction still driving");

    property p_len7;
        rise && !s.cfg[`CSSC_B_DLS] && s.cnt == 4'd6 |-> xfer;
    endproperty
    a_len7: assert property (p_len7) else $error("seven-bit frame not ended");

    property p_len8;
        rise && s.cfg[`CSSC_B_DLS] && s.cnt == 4'd6 |-> !xfer;
    endproperty
    a_len8: assert property (p_len8) else $error("eight-bit frame ended early");

    property p_no_store;
        xfer && !mode[0] |=> $stable(s.rxd);
    endproperty
    a_no_store: assert property (p_no_store) else $error("data stored with receive off");

    property p_tx_off_pin;
        act && !mode[1] |=> p0_o[0] == $past(s.lat[0]);
    endproperty
    a_tx_off_pin: assert property (p_tx_off_pin) else $error("data pin shifted with transmit off");

    property p_eoc_on;
        fe && s.cfg[`CSSC_B_EOC] |=> s.ist[1];
    endproperty
    a_eoc_on: assert property (p_eoc_on) else $error("error interrupt status not set");

    property p_irq_level;
        s.ist[0] && s.ien[0] && !s.msk[`CSSC_B_TMSK] |=> irq_o;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("unmasked transfer interrupt missing");

endmodule : cssc_ctrl

// ==== tb/cssc_master_model.sv ====
// Behavioural external serial master: drives clock, select and data.
// Assumes slave handshake on pin 4 (low and driven = ready), data on pin 0.
`timescale 1ns/100ps
module cssc_master_model (
    // Link lines
    output logic            sck,
    output logic            ss_n,
    output logic            si,
    // Slave pins
    input  wire logic [4:0] pin,
    input  wire logic [4:0] pin_oe
);
    // Idle clock high, select released
    initial begin
        sck = 1'b1;
        ss_n = 1'b1;
        si = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One frame, MSB first; a short count aborts it mid-frame
    task automatic frame(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        int w;
        w = 0;
        rx = 8'h00;
        // Undriven handshake counts as busy, as a pull-up would show it
        while (!(pin_oe[4] && !pin[4]) && w < 1000) begin
            #4;
            w++;
        end
        ss_n = 1'b0;
        for (int i = 7; i > 7 - nb; i--) begin
            #80 sck = 1'b0;
            si = tx[i];
            #80 sck = 1'b1;
            rx[i] = pin_oe[0] ? pin[0] : 1'bx;
        end
        #80 ss_n = 1'b1;
        si = ~si; // No stale value on a released line
    endtask : frame
endmodule : cssc_master_model

// ==== tb/tb_top.sv ====
// Self-checking bench of the serial channel controller.
// Assumes cssc_master_model on the link and byte addresses = word index * 4.
`timescale 1ns/100ps
`include "cssc_map.svh"
module tb_top;
    import cssc_pkg::*;
    logic        clk_sys;
    logic        srst;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        sck;
    logic        si;
    logic        ss_n;
    logic [4:0]  p0_o;
    logic [4:0]  p0_oe;
    logic        irq_o;
    logic [31:0] q;
    logic [7:0]  rx;
    int          errors;
    int          samples_checked;
    int          cycles = 0;

    cssc_ctrl cssc_ctrl_inst (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .sck_i(sck), .si_i(si), .ss_n_i(ss_n), .p0_o(p0_o), .p0_oe(p0_oe),
        .irq_o(irq_o));
    cssc_master_model cssc_master_model_inst (.sck(sck), .ss_n(ss_n), .si(si), .pin(p0_o), .pin_oe(p0_oe));

    ////////////////////////////////////////////////////////////////////////
    // Clock, and a ceiling far above the few thousand cycles needed
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Classic cycle: hold until ack is sampled, then release
    task automatic wb(input logic we, input logic [5:0] w, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {w, 2'b00};
        wb_dat <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        r = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 50) begin
            chk("ack", 32'h1, 32'h0);
            report_and_stop();
        end
    endtask : wb

    task automatic wr(input logic [5:0] w, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, w, d, r);
    endtask : wr

    task automatic rd(input logic [5:0] w);
        wb(1'b0, w, 32'h0, q);
    endtask : rd

    // Load tx data, drive pin 0, show ready on pin 4
    task automatic prep(input logic [7:0] tx);
        wr(`CSSC_A_DATA, {24'h0, tx});
        wr(`CSSC_A_LAT, 32'h07);
        wr(`CSSC_A_DIR, 32'hee);
        repeat (3) @(posedge clk_sys);
    endtask : prep

    task automatic xf(input logic [7:0] tx, input int nb);
        cssc_master_model_inst.frame(tx, nb, rx);
        repeat (30) @(posedge clk_sys);
    endtask : xf

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("oe_rst", 32'h0, {27'h0, p0_oe});
        rd(`CSSC_A_MSK);
        chk("msk_rst", 32'h08, q);
        rd(`CSSC_A_LAT);
        chk("lat_rst", 32'h17, q);
        rd(`CSSC_A_DIR);
        chk("dir_rst", 32'hff, q);
        rd(`CSSC_A_CFG);
        chk("cfg_rst", 32'hc007, q);
        wr(`CSSC_A_CLR, 32'h07);
        rd(`CSSC_A_CLR);
        chk("clr_rd", 32'h0, q);
        rd(`CSSC_A_STOP);
        chk("stop_rd", 32'h0, q);
        rd(6'h3f);
        chk("unmapped", 32'h0, q);
        $display("test reset done");
    endtask : t_reset

    task automatic t_xfer();
        wr(`CSSC_A_IEN, 32'h3);
        wr(`CSSC_A_MSK, 32'h0);
        wr(`CSSC_A_SOE, 32'h1);
        wr(`CSSC_A_START, 32'h1);
        prep(8'ha5);
        chk("oe_out", 32'h11, {27'h0, p0_oe});
        chk("ready", 32'h0, {31'h0, p0_o[4]});
        xf(8'h3c, 8);
        chk("master_rx", 32'ha5, {24'h0, rx});
        chk("release", 32'h4, {29'h0, p0_o[4], p0_oe[4], p0_oe[0]});
        chk("irq_on", 32'h1, {31'h0, irq_o});
        wr(`CSSC_A_MSK, 32'h08);
        repeat (3) @(posedge clk_sys);
        chk("irq_masked", 32'h0, {31'h0, irq_o});
        rd(`CSSC_A_DATA);
        chk("rx_data", 32'h3c, q);
        rd(`CSSC_A_STAT);
        chk("stat", 32'h80, q);
        wr(`CSSC_A_ICLR, 32'h3);
        $display("test transfer done");
    endtask : t_xfer

    task automatic t_errors();
        prep(8'h11);
        xf(8'h01, 8);
        prep(8'h11);
        xf(8'h02, 8);
        rd(`CSSC_A_IST);
        chk("err_irq_off", 32'h0, {31'h0, q[1]});
        wr(`CSSC_A_CLR, 32'h06);
        rd(`CSSC_A_STAT);
        chk("ovf_kept", 32'h89, q);
        wr(`CSSC_A_CLR, 32'h01);
        rd(`CSSC_A_STAT);
        chk("ovf_clr", 32'h88, q);
        rd(`CSSC_A_DATA);
        wr(`CSSC_A_CFG, 32'hc407);
        prep(8'h11);
        xf(8'h0f, 4);
        rd(`CSSC_A_IST);
        chk("err_irq_on", 32'h1, {31'h0, q[1]});
        wr(`CSSC_A_CLR, 32'h03);
        rd(`CSSC_A_STAT);
        chk("fef_kept", 32'h1, {31'h0, q[2]});
        wr(`CSSC_A_CLR, 32'h04);
        rd(`CSSC_A_STAT);
        chk("fef_clr", 32'h0, {31'h0, q[2]});
        wr(`CSSC_A_ICLR, 32'h3);
        wr(`CSSC_A_CFG, 32'hc007);
        $display("test errors done");
    endtask : t_errors

    task automatic t_soe_stop();
        rd(`CSSC_A_DATA);
        wr(`CSSC_A_SOE, 32'h0);
        prep(8'h00);
        xf(8'h55, 8);
        chk("no_engine", 32'hff, {24'h0, rx});
        rd(`CSSC_A_DATA);
        wr(`CSSC_A_SOE, 32'h1);
        wr(`CSSC_A_CFG, 32'h0007);
        prep(8'h00);
        xf(8'h55, 8);
        rd(`CSSC_A_STAT);
        chk("mode_off", 32'h0, {31'h0, q[3]});
        wr(`CSSC_A_STOP, 32'h1);
        rd(`CSSC_A_STAT);
        chk("stopped", 32'h0, {31'h0, q[7]});
        $display("test output enable and stop done");
    endtask : t_soe_stop

    // Seven-bit frames in transmit-only and receive-only modes
    task automatic t_modes();
        wr(`CSSC_A_START, 32'h1);
        wr(`CSSC_A_CFG, 32'h8006);
        prep(8'h5a);
        xf(8'h7f, 7);
        chk("tx7_master_rx", 32'hb4, {24'h0, rx});
        rd(`CSSC_A_STAT);
        chk("tx_only_stat", 32'h80, q);
        wr(`CSSC_A_CFG, 32'h4006);
        prep(8'hff);
        xf(8'hd4, 7);
        chk("rx_only_pin", 32'hfe, {24'h0, rx});
        rd(`CSSC_A_DATA);
        chk("rx7_data", 32'h6a, q);
        wr(`CSSC_A_CFG, 32'hc007);
        $display("test modes and length done");
    endtask : t_modes

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        srst = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'h3;
        wb_dat = 32'h0;
        errors = 0;
        samples_checked = 0;
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (5) @(posedge clk_sys);
        t_reset();
        t_xfer();
        t_errors();
        t_soe_stop();
        t_modes();
        report_and_stop();
    end
endmodule : tb_top
